/* File: hdl/bus_terminal_pkg.sv */
package bus_terminal_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLEAR_MIN_NS = 1000;
    localparam int unsigned CLEAR_MIN_CYC = (CLEAR_MIN_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // widths and word fields
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned CNT_W = 5;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam int unsigned ADR_HI = 15;
    localparam int unsigned ADR_LO = 11;
    localparam int unsigned SA_HI = 9;
    localparam int unsigned SA_LO = 5;

    // ------------------------------------------------------------------
    // register map and status bits
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_MASK = 4'h4;
    localparam logic [3:0] OFS_RX_WORD = 4'h8;
    localparam logic [3:0] OFS_TX_WORD = 4'hc;
    localparam int unsigned ST_W = 4;
    localparam int unsigned ST_WORD = 0;
    localparam int unsigned ST_CMD = 1;
    localparam int unsigned ST_TIMEOUT = 2;
    localparam int unsigned ST_ALLTERM = 3;

    // ------------------------------------------------------------------
    // control pin vector: index and idle level
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W = 9;
    localparam int unsigned P_DCLR = 8;
    localparam int unsigned P_MCLR = 7;
    localparam int unsigned P_INH = 6;
    localparam int unsigned P_LAT_LO = 5;
    localparam int unsigned P_LAT_HI = 4;
    localparam int unsigned P_LD_LO = 3;
    localparam int unsigned P_LD_HI = 2;
    localparam int unsigned P_SEL_LO = 1;
    localparam int unsigned P_SEL_HI = 0;
    localparam logic [8:0] PIN_IDLE = 9'h1cf;

    typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_e;
endpackage : bus_terminal_pkg

/* File: hdl/low_width_detect.sv */
`timescale 1ns/10ps
`default_nettype none
// flags an active-low input once it has stayed low for MIN_CYC cycles
module low_width_detect #(
    parameter int unsigned MIN_CYC = 100
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic level_n_i,
    output logic hit_o
);
    localparam int unsigned CW = $clog2(MIN_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);

    logic [CW-1:0] cnt_q;

    // short glitches never reach the limit, so they clear nothing
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            hit_o <= 1'b0;
        end else if (level_n_i) begin
            cnt_q <= '0;
            hit_o <= 1'b0;
        end else if (cnt_q == LAST) begin
            hit_o <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : low_width_detect
`default_nettype wire

/* File: hdl/bus_terminal_io_control.sv */
// Functional notes
// - decoder clear low 1us re-arms decoder, sync kind low, word ok high.
// - line drive inhibit low forces both line outputs low.
// - received bits appear NRZ on serial output while window is low.
// - receive window low exactly while the 16 data bits shift.
// - master clear low 1us aborts transmit and clears timeout flag.
// - master clear also does everything decoder clear does.
// - all-terminals flag high on valid command word with address all ones.
// - special subaddress flag low on valid command word with subaddress all ones or zeros.
// - low-byte select low drives second-rank receive low byte on D0-D7.
// - low latch high makes first-rank low byte follow D0-D7, else hold.
// - high latch high makes first-rank high byte follow D8-D15, else hold.
// - low load low copies first-rank low byte to second rank; high locks it.
// - high load low copies first-rank high byte to second rank; high locks it.
// - data bus is 16-bit tri-state, D0 the least significant bit.
// - sync kind high after command sync, low after data sync.
// - word ok output goes low when a valid word is received.
`timescale 1ns/10ps
`default_nettype none
module bus_terminal_io_control
    import bus_terminal_pkg::*;
#(
    parameter int unsigned CLEAR_CYC = CLEAR_MIN_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic decoder_clear_n_i,
    input wire logic master_clear_n_i,
    input wire logic line_drive_inhibit_n_i,
    input wire logic latch_lo_i,
    input wire logic latch_hi_i,
    input wire logic load_lo_n_i,
    input wire logic load_hi_n_i,
    input wire logic rx_sel_lo_n_i,
    input wire logic rx_sel_hi_n_i,
    input wire logic [WORD_W-1:0] d_i,
    output logic [WORD_W-1:0] d_o,
    output logic [WORD_W-1:0] d_oe_o,
    input wire logic dec_sync_i,
    input wire logic dec_sync_cmd_i,
    input wire logic dec_bit_stb_i,
    input wire logic dec_bit_i,
    input wire logic dec_word_ok_i,
    input wire logic enc_pos_i,
    input wire logic enc_neg_i,
    input wire logic enc_timeout_i,
    output logic line_pos_o,
    output logic line_neg_o,
    output logic tx_clear_o,
    output logic [WORD_W-1:0] tx_word_o,
    output logic sync_kind_o,
    output logic word_ok_n_o,
    output logic all_term_o,
    output logic special_sa_n_o,
    output logic rx_serial_o,
    output logic rx_window_n_o,
    output logic fail_safe_o,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pin_meta_q, pin_q;
    logic [WORD_W-1:0] d_meta_q, d_q;
    logic dclr_hit, mclr_hit, clr;

    // pins are asynchronous to ref_clk; two stages before any use
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_q <= PIN_IDLE;
            pin_q <= PIN_IDLE;
            d_meta_q <= '0;
            d_q <= '0;
        end else begin
            pin_meta_q <= {decoder_clear_n_i, master_clear_n_i,
                           line_drive_inhibit_n_i, latch_lo_i, latch_hi_i,
                           load_lo_n_i, load_hi_n_i, rx_sel_lo_n_i,
                           rx_sel_hi_n_i};
            pin_q <= pin_meta_q;
            d_meta_q <= d_i;
            d_q <= d_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // clear pulse width qualification
    // ------------------------------------------------------------------
    low_width_detect #(.MIN_CYC(CLEAR_CYC)) u_dclr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .level_n_i(pin_q[P_DCLR]),
        .hit_o(dclr_hit)
    );
    low_width_detect #(.MIN_CYC(CLEAR_CYC)) u_mclr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .level_n_i(pin_q[P_MCLR]),
        .hit_o(mclr_hit)
    );
    assign clr = dclr_hit | mclr_hit; // master clear also clears decoder

    // ------------------------------------------------------------------
    // receive shift window and serial output
    // ------------------------------------------------------------------
    rx_state_e rx_state_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic [WORD_W-1:0] rx1_q, rx2_q;
    logic cmd_word_q;

    // window opens on sync, closes after the 16th bit
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_q <= RX_IDLE;
            bit_cnt_q <= '0;
            rx_window_n_o <= 1'b1;
        end else if (clr) begin
            rx_state_q <= RX_IDLE; // re-armed for a new word
            bit_cnt_q <= '0;
            rx_window_n_o <= 1'b1;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    if (dec_sync_i) begin
                        rx_state_q <= RX_SHIFT;
                        bit_cnt_q <= '0;
                        rx_window_n_o <= 1'b0;
                    end
                end
                RX_SHIFT: begin
                    if (dec_bit_stb_i) begin
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                        if (bit_cnt_q == WORD_BITS - 5'h01) begin
                            rx_state_q <= RX_IDLE;
                            rx_window_n_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // first rank fills msb first; second rank takes it as window closes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx1_q <= '0;
            rx2_q <= '0;
            rx_serial_o <= 1'b0;
        end else if (rx_state_q == RX_SHIFT && dec_bit_stb_i && !clr) begin
            rx1_q <= {rx1_q[WORD_W-2:0], dec_bit_i};
            rx_serial_o <= dec_bit_i; // nrz copy of the bit
            if (bit_cnt_q == WORD_BITS - 5'h01) begin
                rx2_q <= {rx1_q[WORD_W-2:0], dec_bit_i};
            end
        end
    end

    // ------------------------------------------------------------------
    // sync kind, word ok and decode flags
    // ------------------------------------------------------------------
    logic adr_all1, sa_edge;
    assign adr_all1 = &rx2_q[ADR_HI:ADR_LO];
    assign sa_edge = (&rx2_q[SA_HI:SA_LO]) | ~(|rx2_q[SA_HI:SA_LO]);

    // flags stay until the next sync or a clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_kind_o <= 1'b0;
            cmd_word_q <= 1'b0;
            word_ok_n_o <= 1'b1;
            all_term_o <= 1'b0;
            special_sa_n_o <= 1'b1;
        end else if (clr) begin
            sync_kind_o <= 1'b0;
            word_ok_n_o <= 1'b1;
            cmd_word_q <= 1'b0;
            all_term_o <= 1'b0;
            special_sa_n_o <= 1'b1;
        end else if (dec_sync_i && rx_state_q == RX_IDLE) begin
            sync_kind_o <= dec_sync_cmd_i;
            cmd_word_q <= dec_sync_cmd_i;
            word_ok_n_o <= 1'b1;
            all_term_o <= 1'b0;
            special_sa_n_o <= 1'b1;
        end else if (dec_word_ok_i && rx_state_q == RX_IDLE) begin
            word_ok_n_o <= 1'b0;
            all_term_o <= cmd_word_q & adr_all1;
            special_sa_n_o <= ~(cmd_word_q & sa_edge);
        end
    end

    // ------------------------------------------------------------------
    // parallel bus: receive drive and transmit ranks
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] tx1_q, tx_src;

    // bus drive per byte; undriven lines float
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d_o <= '0;
            d_oe_o <= '0;
        end else begin
            d_o <= rx2_q;
            d_oe_o[BYTE_W-1:0] <= {BYTE_W{~pin_q[P_SEL_LO]}};
            d_oe_o[WORD_W-1:BYTE_W] <= {BYTE_W{~pin_q[P_SEL_HI]}};
        end
    end

    // latch high is transparent, so a load sees live bus data
    assign tx_src[BYTE_W-1:0] = pin_q[P_LAT_LO] ? d_q[BYTE_W-1:0]
                                                : tx1_q[BYTE_W-1:0];
    assign tx_src[WORD_W-1:BYTE_W] = pin_q[P_LAT_HI]
                                     ? d_q[WORD_W-1:BYTE_W]
                                     : tx1_q[WORD_W-1:BYTE_W];

    // first rank follows or holds per byte
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx1_q <= '0;
        end else begin
            tx1_q <= tx_src;
        end
    end

    // second rank loads while load is low, locked while high; with high
    // load held low and high latch open, the top line streams serial data
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_word_o <= '0;
        end else begin
            if (!pin_q[P_LD_LO]) begin
                tx_word_o[BYTE_W-1:0] <= tx_src[BYTE_W-1:0];
            end
            if (!pin_q[P_LD_HI]) begin
                tx_word_o[WORD_W-1:BYTE_W] <= tx_src[WORD_W-1:BYTE_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // transmit abort, timeout and line drive
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_clear_o <= 1'b0;
            fail_safe_o <= 1'b0;
        end else begin
            tx_clear_o <= mclr_hit;
            if (enc_timeout_i) begin
                fail_safe_o <= 1'b1; // a timeout beside a clear wins
            end else if (mclr_hit) begin
                fail_safe_o <= 1'b0;
            end
        end
    end

    // a timed-out or inhibited transmitter must not reach the line
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_pos_o <= 1'b0;
            line_neg_o <= 1'b0;
        end else begin
            line_pos_o <= enc_pos_i & pin_q[P_INH] & ~fail_safe_o;
            line_neg_o <= enc_neg_i & pin_q[P_INH] & ~fail_safe_o;
        end
    end

    // ------------------------------------------------------------------
    // status, mask, interrupt and register read
    // ------------------------------------------------------------------
    logic [ST_W-1:0] st_q, mask_q, st_set, st_clr;
    logic word_done;
    assign word_done = dec_word_ok_i && rx_state_q == RX_IDLE && !clr;
    assign st_set[ST_WORD] = word_done;
    assign st_set[ST_CMD] = word_done & cmd_word_q;
    assign st_set[ST_TIMEOUT] = enc_timeout_i;
    assign st_set[ST_ALLTERM] = word_done & cmd_word_q & adr_all1;
    assign st_clr = (wr_i && addr_i == OFS_STATUS) ? wdata_i[ST_W-1:0] : '0;

    // a set in the clearing cycle survives
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
            mask_q <= '0;
        end else begin
            st_q <= (st_q & ~st_clr) | st_set;
            if (wr_i && addr_i == OFS_MASK) begin
                mask_q <= wdata_i[ST_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((st_q & ~st_clr) | st_set) & mask_q);
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                OFS_STATUS: rdata_o <= {28'h0, st_q};
                OFS_MASK: rdata_o <= {28'h0, mask_q};
                OFS_RX_WORD: rdata_o <= {16'h0, rx2_q};
                OFS_TX_WORD: rdata_o <= {16'h0, tx_word_o};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_dclr;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        dclr_hit |=> !sync_kind_o && word_ok_n_o && rx_window_n_o;
    endproperty
    a_dclr: assert property (p_dclr)
        else $error("decoder clear failed");
    property p_mclr;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        mclr_hit |=> !sync_kind_o && word_ok_n_o && tx_clear_o
                     && (!fail_safe_o || $past(enc_timeout_i));
    endproperty
    a_mclr: assert property (p_mclr)
        else $error("master clear failed");
    property p_inh;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pin_q[P_INH] |=> !line_pos_o && !line_neg_o;
    endproperty
    a_inh: assert property (p_inh)
        else $error("line not inhibited");
    property p_serial;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rx_state_q == RX_SHIFT && dec_bit_stb_i && !clr
        |=> rx_serial_o == $past(dec_bit_i);
    endproperty
    a_serial: assert property (p_serial)
        else $error("serial bit wrong");
    property p_window;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(rx_window_n_o) && !$past(clr)
        |-> $past(bit_cnt_q) == WORD_BITS - 5'h01;
    endproperty
    a_window: assert property (p_window)
        else $error("window length wrong");
    property p_allterm;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        word_done |=> all_term_o == $past(cmd_word_q & adr_all1);
    endproperty
    a_allterm: assert property (p_allterm)
        else $error("all-term flag wrong");
    property p_special;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        word_done |=> special_sa_n_o == !$past(cmd_word_q & sa_edge)
                      && !word_ok_n_o;
    endproperty
    a_special: assert property (p_special)
        else $error("subaddr flag wrong");
    property p_drive;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pin_q[P_SEL_LO] ##1 !pin_q[P_SEL_LO] |-> d_oe_o[BYTE_W-1:0] == 8'hff;
    endproperty
    a_drive: assert property (p_drive)
        else $error("low byte not driven");
    property p_float;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        pin_q[P_SEL_HI] |=> d_oe_o[WORD_W-1:BYTE_W] == 8'h00;
    endproperty
    a_float: assert property (p_float)
        else $error("high byte not floating");
    property p_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pin_q[P_LAT_LO] |=> $stable(tx1_q[BYTE_W-1:0]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch did not hold");
    property p_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pin_q[P_LD_HI] && pin_q[P_LAT_HI]
        |=> tx_word_o[WORD_W-1:BYTE_W] == $past(d_q[WORD_W-1:BYTE_W]);
    endproperty
    a_load: assert property (p_load)
        else $error("high load wrong");
    c_word: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(rx_window_n_o) ##[1:400] $fell(word_ok_n_o));
    c_bcast: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(all_term_o));
    c_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(irq_o));
endmodule : bus_terminal_io_control
`default_nettype wire

/* File: dv/decoder_model.sv */
`timescale 1ns/10ps
`default_nettype none
// stands in for the decoder core that feeds the receive side
module decoder_model (
    input wire logic ref_clk_i,
    output logic sync_o,
    output logic sync_cmd_o,
    output logic bit_stb_o,
    output logic bit_o,
    output logic word_ok_o
);
    initial begin
        sync_o = 1'b0;
        sync_cmd_o = 1'b0;
        bit_stb_o = 1'b0;
        bit_o = 1'b0;
        word_ok_o = 1'b0;
    end

    // one sync pulse opens a receive cycle; kind rides on the level
    task automatic start(input logic cmd);
        @(posedge ref_clk_i);
        sync_o <= 1'b1;
        sync_cmd_o <= cmd;
        @(posedge ref_clk_i);
        sync_o <= 1'b0;
        sync_cmd_o <= ~cmd; // kind is only meaningful with the pulse
    endtask : start

    // sixteen strobes, most significant bit first
    task automatic shift(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            bit_stb_o <= 1'b1;
            bit_o <= w[i];
            @(posedge ref_clk_i);
        end
        bit_stb_o <= 1'b0;
        bit_o <= ~w[0]; // stale bit must not look valid
    endtask : shift

    // parity verdict arrives after the last bit
    task automatic ok();
        @(posedge ref_clk_i);
        word_ok_o <= 1'b1;
        @(posedge ref_clk_i);
        word_ok_o <= 1'b0;
    endtask : ok
endmodule : decoder_model
`default_nettype wire

/* File: dv/bus_terminal_io_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module bus_terminal_io_control_tb;
    import bus_terminal_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0;
    logic decoder_clear_n_i = 1'b1, master_clear_n_i = 1'b1;
    logic line_drive_inhibit_n_i = 1'b1, latch_lo_i = 1'b0;
    logic latch_hi_i = 1'b0, load_lo_n_i = 1'b1, load_hi_n_i = 1'b1;
    logic rx_sel_lo_n_i = 1'b1, rx_sel_hi_n_i = 1'b1;
    logic enc_pos_i = 1'b0, enc_neg_i = 1'b0, enc_timeout_i = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic [WORD_W-1:0] bus_q = '0;
    wire logic [WORD_W-1:0] d_i, d_o, d_oe_o, tx_word_o;
    wire logic [31:0] rdata_o;
    wire logic dec_sync_i, dec_sync_cmd_i, dec_bit_stb_i, dec_bit_i;
    wire logic dec_word_ok_i, line_pos_o, line_neg_o, tx_clear_o;
    wire logic sync_kind_o, word_ok_n_o, all_term_o, special_sa_n_o;
    wire logic rx_serial_o, rx_window_n_o, fail_safe_o, irq_o;
    int mismatches = 0, tests_run = 0, cycles = 0;
    localparam logic [15:0] CMD_W = 16'hf81f; // address ones, subaddr zeros

    // bus level: design wins where it drives, else the subsystem value
    assign d_i = (d_oe_o & d_o) | (~d_oe_o & bus_q);

    always #5 ref_clk_i = ~ref_clk_i;

    bus_terminal_io_control #(.CLEAR_CYC(4)) u_bus_terminal_io_control (
        .ref_clk_i, .rst_n_i, .decoder_clear_n_i, .master_clear_n_i,
        .line_drive_inhibit_n_i, .latch_lo_i, .latch_hi_i, .load_lo_n_i,
        .load_hi_n_i, .rx_sel_lo_n_i, .rx_sel_hi_n_i, .d_i, .d_o, .d_oe_o,
        .dec_sync_i, .dec_sync_cmd_i, .dec_bit_stb_i, .dec_bit_i,
        .dec_word_ok_i, .enc_pos_i, .enc_neg_i, .enc_timeout_i, .line_pos_o,
        .line_neg_o, .tx_clear_o, .tx_word_o, .sync_kind_o, .word_ok_n_o,
        .all_term_o, .special_sa_n_o, .rx_serial_o, .rx_window_n_o,
        .fail_safe_o, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);

    decoder_model u_decoder_model (.ref_clk_i, .sync_o(dec_sync_i),
        .sync_cmd_o(dec_sync_cmd_i), .bit_stb_o(dec_bit_stb_i),
        .bit_o(dec_bit_i), .word_ok_o(dec_word_ok_i));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // waits n edges and lets their updates land before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd

    // a clear pin held low well past its qualifying width
    task automatic pulse_low(input bit mclr);
        @(posedge ref_clk_i);
        if (mclr) master_clear_n_i <= 1'b0;
        else decoder_clear_n_i <= 1'b0;
        cyc(12);
    endtask : pulse_low

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic rx_command_word();
        wr(OFS_MASK, 32'hf);
        u_decoder_model.start(1'b1);
        #1;
        chk(rx_window_n_o, 1'b0);
        chk(sync_kind_o, 1'b1);
        u_decoder_model.shift(CMD_W);
        cyc(1);
        chk(rx_window_n_o, 1'b1);
        chk(rx_serial_o, CMD_W[0]);
        u_decoder_model.ok();
        #1;
        chk(word_ok_n_o, 1'b0);
        chk(all_term_o, 1'b1);
        chk(special_sa_n_o, 1'b0);
        chk(irq_o, 1'b1);
        rd(OFS_STATUS, 32'hb);
        rd(OFS_RX_WORD, {16'h0, CMD_W});
        rd(4'h2, 32'h0);
        wr(OFS_STATUS, 32'hb);
        rd(OFS_STATUS, 32'h0);
        chk(irq_o, 1'b0);
    endtask : rx_command_word

    task automatic select_bytes();
        rx_sel_lo_n_i <= 1'b0;
        cyc(4);
        chk(d_oe_o, 16'h00ff);
        chk(d_o & d_oe_o, 16'h001f);
        rx_sel_lo_n_i <= 1'b1;
        rx_sel_hi_n_i <= 1'b0;
        cyc(4);
        chk(d_oe_o, 16'hff00);
        rx_sel_hi_n_i <= 1'b1;
        cyc(4);
        chk(d_oe_o, 16'h0);
    endtask : select_bytes

    task automatic decoder_clear_and_data_sync();
        pulse_low(1'b0);
        chk(word_ok_n_o, 1'b1);
        chk(sync_kind_o, 1'b0);
        decoder_clear_n_i <= 1'b1;
        cyc(4);
        u_decoder_model.start(1'b1);
        u_decoder_model.start(1'b0); // ignored: window already open
        #1;
        chk(sync_kind_o, 1'b1);
        u_decoder_model.shift(16'h1234);
        u_decoder_model.start(1'b0);
        #1;
        chk(sync_kind_o, 1'b0);
        u_decoder_model.shift(16'h0);
    endtask : decoder_clear_and_data_sync

    task automatic transmit_ranks();
        latch_lo_i <= 1'b1;
        latch_hi_i <= 1'b1;
        load_lo_n_i <= 1'b0;
        load_hi_n_i <= 1'b0;
        bus_q <= 16'ha5c3;
        cyc(4);
        chk(tx_word_o, 16'ha5c3);
        latch_lo_i <= 1'b0;
        latch_hi_i <= 1'b0;
        cyc(4);
        bus_q <= 16'h3c5a;
        cyc(4);
        chk(tx_word_o, 16'ha5c3);
        load_lo_n_i <= 1'b1;
        load_hi_n_i <= 1'b1;
        latch_lo_i <= 1'b1;
        latch_hi_i <= 1'b1;
        cyc(4);
        chk(tx_word_o, 16'ha5c3);
        rd(OFS_TX_WORD, 32'ha5c3);
        // serial use: high load held low, high latch open, top line streams
        load_hi_n_i <= 1'b0;
        bus_q <= 16'h8000;
        cyc(4);
        chk(tx_word_o, 16'h80c3);
        bus_q <= 16'h0000;
        cyc(4);
        chk(tx_word_o, 16'h00c3);
        load_hi_n_i <= 1'b1;
    endtask : transmit_ranks

    task automatic line_and_master_clear();
        enc_pos_i <= 1'b1;
        cyc(2);
        chk({line_pos_o, line_neg_o}, 2'b10);
        line_drive_inhibit_n_i <= 1'b0;
        enc_neg_i <= 1'b1;
        cyc(4);
        chk({line_pos_o, line_neg_o}, 2'b00);
        line_drive_inhibit_n_i <= 1'b1;
        wr(OFS_MASK, 32'h0);
        enc_timeout_i <= 1'b1;
        cyc(1);
        enc_timeout_i <= 1'b0;
        cyc(2);
        chk(fail_safe_o, 1'b1);
        chk(line_pos_o, 1'b0);
        chk(irq_o, 1'b0);
        rd(OFS_STATUS, 32'h4);
        u_decoder_model.start(1'b1);
        u_decoder_model.shift(CMD_W);
        u_decoder_model.ok();
        pulse_low(1'b1);
        chk(tx_clear_o, 1'b1);
        chk(fail_safe_o, 1'b0);
        chk(word_ok_n_o, 1'b1);
        chk(sync_kind_o, 1'b0);
        master_clear_n_i <= 1'b1;
        cyc(6);
        chk(tx_clear_o, 1'b0);
        chk({line_pos_o, line_neg_o}, 2'b11);
    endtask : line_and_master_clear

    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        cyc(20);
        rst_n_i <= 1'b1;
        cyc(1);
        chk({word_ok_n_o, special_sa_n_o, rx_window_n_o}, 3'b111);
        chk({sync_kind_o, irq_o, d_oe_o}, 18'h0);
        rx_command_word();
        select_bytes();
        decoder_clear_and_data_sync();
        transmit_ranks();
        line_and_master_clear();
        final_report();
    end
endmodule : bus_terminal_io_control_tb
`default_nettype wire
